// *** design/banked_mem_cfg.svh ***
// Constants of the banked data memory: file offsets, field positions,
// reset values and address ranges.
// Assumes it is included by bare name, once per compilation unit.
//
// Contract
// RULE1: Status bits 6:5 choose bank; 00,01 implemented
// RULE2: Software keeps upper bank bit clear
// RULE3: Each bank spans 128 locations, up to 7Fh
// RULE4: Special registers low, static RAM above them
// RULE5: Busy special registers mirrored in both banks
// RULE6: Unimplemented locations and bits read zero
// RULE7: Every location reachable directly or through pointer
// RULE8: Window at 00h/80h redirects to pointer target
// RULE9: Window read with pointer zero gives 00h
// RULE10: Window write with pointer zero stores nothing
// RULE11: Indirect address is bank bit plus pointer; decode ignores the bank bit, so indirect access stays in banks 0/1
// RULE12: Direct address is bank bits plus field
`ifndef BANKED_MEM_CFG_SVH
`define BANKED_MEM_CFG_SVH

// ****************************************************
// File offsets within a bank (register index)
// ****************************************************
`define RF_IDX_WINDOW 7'h00
`define RF_IDX_STATUS 7'h03
`define RF_IDX_POINTER 7'h04
`define RF_IDX_PCLATCH 7'h0A

// ****************************************************
// Status field positions
// ****************************************************
`define ST_IND_BANK 7
`define ST_BANK_HI 6
`define ST_BANK_LO 5

// ****************************************************
// Reset values
// ****************************************************
`define STATUS_RST 8'h00
`define POINTER_RST 8'h00
`define PCLATCH_RST 5'h00

// ****************************************************
// Static RAM ranges and placement
// ****************************************************
`define GPR_FIRST 7'h20
`define GPR_LAST_B1 7'h3F
`define RAM_B1_SHIFT 7'h40
`define RAM_DEPTH 128

// ****************************************************
// APB window: word index in paddr[8:2], paddr[11:9] must be 0, paddr[1:0] ignored
// ****************************************************
`define APB_AW 12
`endif

// *** design/banked_mem_pkg.sv ***
// Types of the banked data memory: APB carriers, phases, decode result.
// Assumes banked_mem_cfg.svh is not needed here; widths are local.
package banked_mem_pkg;

	// ****************************************************
	// APB request and answer carriers
	// ****************************************************
	typedef struct packed {
		logic psel;
		logic penable;
		logic pwrite;
		logic [11:0] paddr;
		logic [31:0] pwdata;
	} apb_req_s;

	typedef struct packed {
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
	} apb_rsp_s;

	// Transfer phase of the slave
	typedef enum logic [1:0] {
		PH_IDLE = 2'b00,
		PH_WAIT = 2'b01,
		PH_DONE = 2'b10
	} phase_e;

	// What an effective address lands on
	typedef enum logic [2:0] {
		RG_NONE = 3'b000,
		RG_WINDOW = 3'b001,
		RG_STATUS = 3'b010,
		RG_POINTER = 3'b011,
		RG_PCLATCH = 3'b100,
		RG_RAM = 3'b101
	} region_e;

	// Decoded access
	typedef struct packed {
		logic indirect;
		logic [8:0] eff;
		region_e region;
		logic [6:0] ram_idx;
	} dec_s;

	// Whole state of the slave
	typedef struct packed {
		phase_e phase;
		logic [7:0] status;
		logic [7:0] pointer;
		logic [4:0] pclatch;
		dec_s dec;
		logic [7:0] prdata;
		logic pready;
		logic pslverr;
	} state_s;

endpackage : banked_mem_pkg

// *** design/gpr_store.sv ***
// Static RAM of the general purpose registers, registered read.
// Assumes one clock; write and read address come from the owner.
`timescale 1ns/100ps
`default_nettype none
module gpr_store #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 128,
	parameter int AW = 7
) (
	input wire logic i_mclk,
	input wire logic i_rst,
	input wire logic i_we,
	input wire logic [AW-1:0] i_addr,
	input wire logic [WIDTH-1:0] i_wdata,
	output logic [WIDTH-1:0] o_rdata
);

	// Storage array, contents undefined after reset like real SRAM
	logic [WIDTH-1:0] mem [DEPTH];

	// ****************************************************
	// Write port and registered read
	// ****************************************************
	always_ff @(posedge i_mclk) begin
		if (i_we) begin
			mem[i_addr] <= i_wdata;
		end
		// Read data register is cleared so the output is defined
		if (i_rst) begin
			o_rdata <= '0;
		end else begin
			o_rdata <= mem[i_addr];
		end
	end

endmodule : gpr_store
`default_nettype wire

// *** design/banked_mem.sv ***
// Banked file-register memory with direct and indirect access, APB slave.
// Assumes the core reaches file addresses as APB word indices 0..7Fh.
`timescale 1ns/100ps
`default_nettype none
`include "banked_mem_cfg.svh"
module banked_mem #(
	parameter int RAM_DEPTH = `RAM_DEPTH
) (
	input wire logic i_mclk,
	input wire logic i_rst,
	input wire banked_mem_pkg::apb_req_s i_apb,
	output banked_mem_pkg::apb_rsp_s o_apb,
	output logic [7:0] o_status,
	output logic [7:0] o_pointer,
	output logic [4:0] o_pclatch
);
	import banked_mem_pkg::*;

	// ****************************************************
	// State and helpers
	// ****************************************************
	state_s cur_reg; // Registered state
	state_s cur_next; // Next state
	logic access; // Access phase present
	logic in_range; // Address inside the file window
	dec_s dec; // Decode of the current request
	logic mem_we; // RAM write strobe
	logic [6:0] mem_addr; // RAM address
	logic [7:0] mem_rdata; // RAM registered read data
	logic [7:0] wbyte; // Write data low byte

	// Reset image of the whole state
	localparam state_s ST_RST = '{
		phase: PH_IDLE,
		status: `STATUS_RST,
		pointer: `POINTER_RST,
		pclatch: `PCLATCH_RST,
		dec: '0,
		prdata: 8'h00,
		pready: 1'b0,
		pslverr: 1'b0
	};

	// ****************************************************
	// Address decode, used on read and on write
	// ****************************************************
	function automatic dec_s decode(
		input logic [6:0] field,
		input logic [7:0] st,
		input logic [7:0] ptr
	);
		dec_s d;
		logic [6:0] off;
		logic bank_hi;
		logic bank_lo;
		d = '0;
		// Field zero is the window: go through the pointer
		d.indirect = (field == `RF_IDX_WINDOW); // RULE8
		if (d.indirect) begin
			d.eff = {st[`ST_IND_BANK], ptr}; // RULE11
		end else begin
			d.eff = {st[`ST_BANK_HI], st[`ST_BANK_LO], field}; // RULE12
		end
		off = d.eff[6:0]; // RULE3
		// Indirect bank bit is unused, so indirect stays in banks 0/1
		bank_hi = d.indirect ? 1'b0 : d.eff[8]; // RULE11
		bank_lo = d.eff[7];
		d.region = RG_NONE;
		d.ram_idx = 7'h00;
		if (bank_hi) begin
			// Banks 2 and 3 are absent
			d.region = RG_NONE; // RULE1
		end else if (off == `RF_IDX_WINDOW) begin
			d.region = RG_WINDOW; // RULE8
		end else if (off == `RF_IDX_STATUS) begin
			// Same register in both banks
			d.region = RG_STATUS; // RULE5
		end else if (off == `RF_IDX_POINTER) begin
			d.region = RG_POINTER; // RULE5
		end else if (off == `RF_IDX_PCLATCH) begin
			d.region = RG_PCLATCH; // RULE5
		end else if (off >= `GPR_FIRST) begin
			// RAM sits above the special registers
			if (!bank_lo) begin
				d.region = RG_RAM; // RULE4
				d.ram_idx = 7'(off - `GPR_FIRST);
			end else if (off <= `GPR_LAST_B1) begin
				// Bank 1 RAM packs after the 96 bytes of bank 0
				d.region = RG_RAM; // RULE4
				d.ram_idx = 7'(off + `RAM_B1_SHIFT);
			end
		end
		return d;
	endfunction : decode

	// ****************************************************
	// Next-state logic
	// ****************************************************
	always_comb begin
		cur_next = cur_reg;
		access = i_apb.psel & i_apb.penable;
		// Anything outside 128 word indices is unmapped
		in_range = (i_apb.paddr[11:9] == 3'h0);
		// Direct or indirect, all 128 offsets decode
		dec = decode(i_apb.paddr[8:2], cur_reg.status,
			cur_reg.pointer); // RULE7
		wbyte = i_apb.pwdata[7:0];
		mem_we = 1'b0;
		mem_addr = dec.ram_idx;
		unique case (cur_reg.phase)
			PH_IDLE: begin
				cur_next.pready = 1'b0;
				cur_next.pslverr = 1'b0;
				// RAM read starts now; data registered next edge
				if (access) begin
					cur_next.dec = dec;
					cur_next.phase = PH_WAIT;
				end
			end
			PH_WAIT: begin
				// Pick the answer; absent places give zero
				cur_next.prdata = 8'h00; // RULE6
				if (in_range) begin
					unique case (cur_reg.dec.region)
						RG_WINDOW: begin
							// Window seen through itself reads 00h
							cur_next.prdata = 8'h00; // RULE9
						end
						RG_STATUS: begin
							cur_next.prdata = cur_reg.status;
						end
						RG_POINTER: begin
							cur_next.prdata = cur_reg.pointer;
						end
						RG_PCLATCH: begin
							// Upper three bits are not implemented
							cur_next.prdata = {3'h0, cur_reg.pclatch}; // RULE6
						end
						RG_RAM: begin
							cur_next.prdata = mem_rdata;
						end
						RG_NONE: begin
							cur_next.prdata = 8'h00; // RULE6
						end
						default: begin
							cur_next.prdata = 8'h00;
						end
					endcase
				end
				cur_next.pready = 1'b1;
				cur_next.pslverr = ~in_range;
				cur_next.phase = PH_DONE;
			end
			PH_DONE: begin
				// Master samples pready at this edge: commit writes
				cur_next.pready = 1'b0;
				cur_next.pslverr = 1'b0;
				cur_next.phase = PH_IDLE;
				if (i_apb.pwrite && in_range) begin
					unique case (dec.region)
						RG_WINDOW: begin
							// Window write with pointer zero: no store
							cur_next.status = cur_reg.status; // RULE10
						end
						RG_STATUS: begin
							cur_next.status = wbyte;
						end
						RG_POINTER: begin
							cur_next.pointer = wbyte;
						end
						RG_PCLATCH: begin
							cur_next.pclatch = wbyte[4:0];
						end
						RG_RAM: begin
							mem_we = 1'b1;
						end
						RG_NONE: begin
							// Absent location: write dropped
							mem_we = 1'b0; // RULE6
						end
						default: begin
							mem_we = 1'b0;
						end
					endcase
				end
			end
			default: begin
				// Illegal phase code recovers to idle
				cur_next.phase = PH_IDLE;
				cur_next.pready = 1'b0;
			end
		endcase
	end

	// ****************************************************
	// State register
	// ****************************************************
	always_ff @(posedge i_mclk) begin
		if (i_rst) begin
			cur_reg <= ST_RST;
		end else begin
			cur_reg <= cur_next;
		end
	end

	// ****************************************************
	// General purpose RAM
	// ****************************************************
	gpr_store #(
		.WIDTH(8),
		.DEPTH(RAM_DEPTH),
		.AW(7)
	) u_gpr (
		.i_mclk(i_mclk),
		.i_rst(i_rst),
		.i_we(mem_we),
		.i_addr(mem_addr),
		.i_wdata(wbyte),
		.o_rdata(mem_rdata)
	);

	// ****************************************************
	// Outputs, all from the state register
	// ****************************************************
	// Upper data bits are constant zero, not logic
	assign o_apb = '{
		prdata: {24'h000000, cur_reg.prdata},
		pready: cur_reg.pready,
		pslverr: cur_reg.pslverr
	};
	assign o_status = cur_reg.status;
	assign o_pointer = cur_reg.pointer;
	assign o_pclatch = cur_reg.pclatch;

	// ****************************************************
	// Assertions
	// ****************************************************
	default clocking cb @(posedge i_mclk);
	endclocking
	default disable iff (i_rst);

	// Helpers
	logic wait_dir; // Direct access being answered
	logic wait_ind; // Indirect access being answered
	assign wait_dir = (cur_reg.phase == PH_WAIT) && !cur_reg.dec.indirect;
	assign wait_ind = (cur_reg.phase == PH_WAIT) && cur_reg.dec.indirect;

	// Direct bank taken from status bits 6:5
	bank_select_a: assert property ( // RULE1
		wait_dir |-> cur_reg.dec.eff[8:7] ==
			{cur_reg.status[`ST_BANK_HI], cur_reg.status[`ST_BANK_LO]})
		else $error("direct bank differs from status bits");

	// Direct low address equals the file field
	direct_form_a: assert property ( // RULE12
		wait_dir |-> cur_reg.dec.eff[6:0] == i_apb.paddr[8:2])
		else $error("direct address not formed from field");

	// RAM never below the special register area
	ram_span_a: assert property ( // RULE3
		(cur_reg.phase == PH_WAIT && cur_reg.dec.region == RG_RAM)
			|-> cur_reg.dec.eff[6:0] >= `GPR_FIRST)
		else $error("RAM decoded inside special register area");

	// Mirrored latch found at 0Ah of either bank
	latch_mirror_a: assert property ( // RULE5
		(wait_dir && cur_reg.dec.eff[8] == 1'b0 &&
			cur_reg.dec.eff[6:0] == `RF_IDX_PCLATCH)
			|-> cur_reg.dec.region == RG_PCLATCH)
		else $error("latch mirror missed");

	// Indirect address is the pointer
	indirect_addr_a: assert property ( // RULE8
		wait_ind |-> cur_reg.dec.eff[7:0] == cur_reg.pointer)
		else $error("indirect address not the pointer");

	// Window read through pointer zero yields 00h with the answer
	window_zero_a: assert property ( // RULE9
		(wait_ind && cur_reg.pointer == 8'h00)
			|=> o_apb.pready && o_apb.prdata == 32'h0)
		else $error("window self read not zero");

	// Window write through pointer zero leaves everything alone
	window_nowrite_a: assert property ( // RULE10
		(cur_reg.phase == PH_DONE && i_apb.pwrite &&
			dec.region == RG_WINDOW)
			|=> $stable(o_status) && $stable(o_pointer) &&
				$stable(o_pclatch) && !$past(mem_we))
		else $error("window self write stored data");

	// Absent location reads zero
	unimpl_zero_a: assert property ( // RULE6
		(cur_reg.phase == PH_WAIT && cur_reg.dec.region == RG_NONE)
			|=> o_apb.prdata == 32'h0)
		else $error("absent location read not zero");

	// Answer two edges after the access is seen, one cycle wide
	ready_time_a: assert property ( // RULE7
		(cur_reg.phase == PH_IDLE && access)
			|-> ##2 o_apb.pready ##1 !o_apb.pready)
		else $error("pready timing wrong");

	// Direct access into bank 2 or 3 lands nowhere
	absent_bank_a: assert property ( // RULE1
		(wait_dir && cur_reg.dec.eff[8]) |-> cur_reg.dec.region == RG_NONE)
		else $error("absent bank decoded to a location");

	// Indirect upper bit is the indirect bank bit of status
	ind_form_a: assert property ( // RULE11
		wait_ind |-> cur_reg.dec.eff[8] == cur_reg.status[`ST_IND_BANK])
		else $error("indirect upper bit not from status");

	// Outside the file window: error flag and zero data
	unmapped_err_a: assert property ( // RULE6
		(cur_reg.phase == PH_WAIT && i_apb.paddr[11:9] != 3'h0)
			|=> o_apb.pslverr && o_apb.prdata == 32'h0)
		else $error("unmapped access not refused");

	// Write to an absent location changes nothing
	absent_write_a: assert property ( // RULE6
		(cur_reg.phase == PH_DONE && i_apb.pwrite &&
			dec.region == RG_NONE)
			|=> $stable(o_status) && $stable(o_pointer) &&
				$stable(o_pclatch) && !$past(mem_we))
		else $error("absent location write stored data");

	// RAM is written only at the edge the master takes the answer
	ram_write_a: assert property ( // RULE4
		mem_we |-> cur_reg.phase == PH_DONE && i_apb.pwrite &&
			dec.region == RG_RAM)
		else $error("RAM written outside a write answer");

	// Scenarios
	ram_read_c: cover property (
		cur_reg.phase == PH_WAIT && cur_reg.dec.region == RG_RAM &&
			!i_apb.pwrite);
	ind_write_c: cover property (
		cur_reg.phase == PH_DONE && i_apb.pwrite && dec.indirect &&
			dec.region == RG_RAM);
	bank1_c: cover property (wait_dir && cur_reg.dec.eff[8:7] == 2'b01);
	self_read_c: cover property (wait_ind && cur_reg.pointer == 8'h00);
	// Direct access into an absent bank
	bank2_c: cover property (wait_dir && cur_reg.dec.eff[8]);

endmodule : banked_mem
`default_nettype wire

// *** tb/core_model.sv ***
// Core model: issues file-register reads and writes over APB.
// Assumes one clock shared with the memory; the bench owns reset.
`timescale 1ns/100ps
`default_nettype none
module core_model (
	input wire logic i_mclk,
	output banked_mem_pkg::apb_req_s o_apb,
	input wire banked_mem_pkg::apb_rsp_s i_apb
);
	import banked_mem_pkg::*;

	// Idle bus from time zero
	initial begin
		o_apb = '0;
	end

	// Status image; upper bank bit kept clear for forward safety
	function automatic logic [7:0] st_val(input logic ib, input logic b1);
		return {ib, 1'b0, b1, 5'h00};
	endfunction : st_val

	// ****************************************************
	// One APB transfer: setup, access, wait for ready
	// ****************************************************
	task automatic xfer(input logic wr, input logic [11:0] a,
		input logic [7:0] d, output logic [7:0] q, output logic err,
		output logic to);
		int n;
		n = 0;
		@(posedge i_mclk);
		o_apb.psel <= 1'b1;
		o_apb.penable <= 1'b0;
		o_apb.pwrite <= wr;
		o_apb.paddr <= a;
		o_apb.pwdata <= {24'h000000, d};
		@(posedge i_mclk);
		o_apb.penable <= 1'b1;
		// Bounded wait; request held until ready is sampled
		do begin
			@(posedge i_mclk);
			n++;
		end while (i_apb.pready !== 1'b1 && n < 50);
		to = (n >= 50);
		q = i_apb.prdata[7:0];
		err = i_apb.pslverr;
		o_apb.psel <= 1'b0;
		o_apb.penable <= 1'b0;
	endtask : xfer
endmodule : core_model
`default_nettype wire

// *** tb/banked_mem_tb_top.sv ***
// Bench for the banked memory: direct, indirect and mirrored accesses.
// Assumes core_model drives the APB side; expectations are hand-derived.
`timescale 1ns/100ps
`default_nettype none
module banked_mem_tb_top;
	import banked_mem_pkg::*;

	logic i_mclk;
	logic i_rst;
	apb_req_s req;
	apb_rsp_s rsp;
	logic [7:0] st;
	logic [7:0] ptr;
	logic [4:0] pcl;
	int n_fail = 0;
	int total_checks = 0;

	banked_mem #(.RAM_DEPTH(128)) uut (.i_mclk(i_mclk), .i_rst(i_rst),
		.i_apb(req), .o_apb(rsp), .o_status(st), .o_pointer(ptr),
		.o_pclatch(pcl));
	core_model u_core (.i_mclk(i_mclk), .o_apb(req), .i_apb(rsp));

	// 125 MHz clock
	initial begin
		i_mclk = 1'b0;
		forever #4 i_mclk = ~i_mclk;
	end

	// ****************************************************
	// Compare, verdict and access helpers
	// ****************************************************
	task automatic chk(input string nm, input logic [7:0] e,
		input logic [7:0] g);
		total_checks++;
		if (g !== e) begin
			n_fail++;
			$display("MISMATCH %s expected %h seen %h", nm, e, g);
		end
	endtask : chk

	task automatic close_out();
		$display("checks %0d mismatches %0d", total_checks, n_fail);
		if (n_fail == 0 && total_checks > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : close_out

	// Raw access; a hang counts and ends the run
	task automatic op(input logic w, input logic [11:0] a,
		input logic [7:0] d, output logic [7:0] q, output logic err);
		logic t;
		u_core.xfer(w, a, d, q, err, t);
		if (t) begin
			n_fail++;
			$display("MISMATCH pready expected 1 seen 0");
			close_out();
		end
	endtask : op

	// File index f sits at byte address 4*f
	task automatic wr(input logic [6:0] f, input logic [7:0] d);
		logic [7:0] q;
		logic e;
		op(1'b1, {3'h0, f, 2'h0}, d, q, e);
		// Committed value shows on the outputs only after the pready edge
		@(negedge i_mclk);
	endtask : wr

	task automatic rd(input logic [6:0] f, input logic [7:0] x);
		logic [7:0] q;
		logic e;
		op(1'b0, {3'h0, f, 2'h0}, 8'h00, q, e);
		chk("file read", x, q);
		chk("pslverr", 8'h00, {7'h00, e});
	endtask : rd

	// ****************************************************
	// Main sequence
	// ****************************************************
	initial begin
		logic [7:0] q;
		logic e;
		i_rst = 1'b1;
		repeat (6) @(posedge i_mclk);
		i_rst <= 1'b0;
		// Reset values
		chk("status", 8'h00, st);
		chk("pointer", 8'h00, ptr);
		chk("pclatch", 8'h00, {3'h0, pcl});
		$display("test reset done");
		// Bank 0 RAM, both ends of the span
		wr(7'h20, 8'hA5);
		wr(7'h7F, 8'h5A);
		rd(7'h20, 8'hA5);
		rd(7'h7F, 8'h5A);
		rd(7'h01, 8'h00);
		$display("test bank0 done");
		// Bank 1: own RAM, empty top, mirrored latch
		wr(7'h03, u_core.st_val(1'b0, 1'b1));
		chk("status", 8'h20, st);
		wr(7'h20, 8'h3C);
		rd(7'h20, 8'h3C);
		wr(7'h40, 8'h99);
		rd(7'h40, 8'h00);
		wr(7'h0A, 8'hFF);
		chk("pclatch", 8'h1F, {3'h0, pcl});
		wr(7'h03, u_core.st_val(1'b0, 1'b0));
		rd(7'h0A, 8'h1F);
		rd(7'h20, 8'hA5);
		$display("test bank1 done");
		// Indirect access, bank bit ignored
		wr(7'h04, 8'h20);
		rd(7'h00, 8'hA5);
		wr(7'h04, 8'hA0);
		rd(7'h00, 8'h3C);
		wr(7'h03, u_core.st_val(1'b1, 1'b0));
		wr(7'h04, 8'h21);
		wr(7'h00, 8'h6E);
		rd(7'h21, 8'h6E);
		$display("test indirect done");
		// Window on itself: read zero, write dropped
		wr(7'h04, 8'h00);
		wr(7'h00, 8'h77);
		rd(7'h00, 8'h00);
		chk("pointer", 8'h00, ptr);
		chk("status", 8'h80, st);
		rd(7'h20, 8'hA5);
		wr(7'h04, 8'h80);
		rd(7'h00, 8'h00);
		$display("test self window done");
		// Unimplemented bank 2 on purpose; pointer parked on status
		wr(7'h04, 8'h03);
		wr(7'h03, 8'h40);
		wr(7'h20, 8'h11);
		rd(7'h20, 8'h00);
		// Direct status write falls into bank 2 and is dropped
		wr(7'h03, 8'h00);
		chk("status", 8'h40, st);
		// Only the window still reaches status
		rd(7'h00, 8'h40);
		wr(7'h00, 8'h00);
		chk("status", 8'h00, st);
		rd(7'h20, 8'hA5);
		$display("test bank2 done");
		// Address outside the file window
		op(1'b0, 12'h200, 8'h00, q, e);
		chk("pslverr", 8'h01, {7'h00, e});
		chk("prdata", 8'h00, q);
		$display("test unmapped done");
		close_out();
	end
endmodule : banked_mem_tb_top
`default_nettype wire
